// ===== hw/rsadc_pkg.sv
// Constants and types shared by the RS485 auto direction control block
package rsadc_pkg;

  // Clock and hold-off timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int HOLD_SHORT_NS = 10000;
  localparam int HOLD_LONG_NS = 50000;
  localparam int HOLD_SHORT_CYC_I = (HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_LONG_CYC_I = (HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 10;
  localparam logic [HOLD_W-1:0] HOLD_SHORT_CYC = HOLD_SHORT_CYC_I[HOLD_W-1:0];
  localparam logic [HOLD_W-1:0] HOLD_LONG_CYC = HOLD_LONG_CYC_I[HOLD_W-1:0];
  localparam logic [HOLD_W-1:0] HOLD_ONE = 10'h001;
  localparam logic [HOLD_W-1:0] HOLD_ZERO = 10'h000;

  // Register offsets (byte addresses)
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] HOLD_OFS = 12'h008;

  // Control register fields
  localparam int CTRL_W = 7;
  localparam int CTRL_USE_REG = 0;
  localparam int CTRL_SW_LSB = 1;
  localparam int CTRL_SW_MSB = 5;
  localparam int CTRL_DELAY = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  // Status register fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_MODE_MSB = 1;
  localparam int STAT_DELAY = 2;
  localparam int STAT_DRV = 3;
  localparam int STAT_RX_EN = 4;
  localparam int STAT_HS_DRV = 5;

  // Mode switch patterns, ordered {e, d, c, b, a}
  localparam logic [4:0] SW_RS422 = 5'h08;
  localparam logic [4:0] SW_RS485_4W = 5'h0a;
  localparam logic [4:0] SW_RS485_2W = 5'h0b;

  // Synchroniser layout and reset
  localparam int SYNC_W = 10;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 10'h00f;

  // Idle (mark) level of serial data
  localparam logic LINE_IDLE = 1'b1;

  typedef enum logic [1:0] {
    MODE_RS422 = 2'b00,
    MODE_RS485_4W = 2'b01,
    MODE_RS485_2W = 2'b10,
    MODE_INVALID = 2'b11
  } rsadc_mode_t;

  typedef enum logic {
    DIR_RECEIVE = 1'b0,
    DIR_SEND = 1'b1
  } rsadc_dir_t;

endpackage

// ===== hw/rsadc_sync.sv
// Three-flop input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module rsadc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  generate
    if (W < 1) begin : g_bad_width
      $error("rsadc_sync width must be at least one");
    end
  endgenerate

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } rsadc_sync_state_t;

  rsadc_sync_state_t q;
  rsadc_sync_state_t next_q;

  always_comb begin
    next_q = q;
    next_q.s1 = async_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        next_q.out[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      q <= next_q;
    end
  end

  assign sync_out = q.out;

endmodule
`default_nettype wire

// ===== hw/rsadc_top.sv
// RS422/RS485 line direction control with APB register access
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - RS422 mode: all receivers and drivers always enabled, no direction switching.
// - RS422 carries data and handshake each way; RS485 modes carry data only.
// - RS485 modes: driver turns on when sending starts, released after it ends.
// - RS485 4-wire: receive channel always enabled.
// - RS485 2-wire: receive disabled while driver on, enabled when released.
// - Mode decoded from switches a to e per fixed patterns.
// - Driver held active for a hold-off delay after the telegram ends.
// - Hold-off is 10 us with delay select on, 50 us when off.
module rsadc_top #(
  parameter int HOLD_SHORT_CYCLES = rsadc_pkg::HOLD_SHORT_CYC_I,
  parameter int HOLD_LONG_CYCLES = rsadc_pkg::HOLD_LONG_CYC_I
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_data_in,
  input wire logic hs_in,
  output logic rx_data_out,
  output logic hs_out,
  input wire logic mode_select_bit_a,
  input wire logic mode_select_bit_b,
  input wire logic mode_select_bit_c,
  input wire logic mode_select_bit_d,
  input wire logic mode_select_bit_e,
  input wire logic holdoff_delay_select,
  input wire logic line_data_i,
  output logic line_data_o,
  output logic line_data_oe_n,
  input wire logic line_hs_i,
  output logic line_hs_o,
  output logic line_hs_oe_n,
  output logic line_rx_en
);

  // Hold-off lengths in clock cycles; the counter must be able to reach them
  localparam int HOLD_MAX = (1 << rsadc_pkg::HOLD_W) - 1;
  localparam logic [rsadc_pkg::HOLD_W-1:0] SHORT_LEN = HOLD_SHORT_CYCLES[rsadc_pkg::HOLD_W-1:0];
  localparam logic [rsadc_pkg::HOLD_W-1:0] LONG_LEN = HOLD_LONG_CYCLES[rsadc_pkg::HOLD_W-1:0];

  // Refuse hold-off counts the counter cannot serve
  generate
    if (HOLD_SHORT_CYCLES < 1 || HOLD_SHORT_CYCLES > HOLD_MAX) begin : g_bad_short
      $error("rsadc_top short hold-off count out of range");
    end
    if (HOLD_LONG_CYCLES < 1 || HOLD_LONG_CYCLES > HOLD_MAX) begin : g_bad_long
      $error("rsadc_top long hold-off count out of range");
    end
  endgenerate

  typedef struct packed {
    logic [31:0] prdata;
    logic [rsadc_pkg::CTRL_W-1:0] ctrl;
    rsadc_pkg::rsadc_dir_t dir;
    logic [rsadc_pkg::HOLD_W-1:0] hold_cnt;
    logic tx_prev;
    logic line_tx;
    logic data_oe_n;
    logic rx_en;
    logic hs_tx;
    logic hs_oe_n;
    logic rx_data;
    logic hs_data;
  } rsadc_state_t;

  rsadc_state_t q;
  rsadc_state_t next_q;

  logic [rsadc_pkg::SYNC_W-1:0] raw_in;
  logic [rsadc_pkg::SYNC_W-1:0] syn;
  logic tx_s;
  logic hs_s;
  logic line_rx_s;
  logic line_hs_s;
  logic [4:0] pin_sw;
  logic pin_delay;
  logic [4:0] sw;
  logic delay_sel;
  rsadc_pkg::rsadc_mode_t mode;
  logic rs485;
  logic activity;
  logic [rsadc_pkg::HOLD_W-1:0] hold_len;
  logic [rsadc_pkg::ADDR_W-1:0] addr;
  logic hit;
  logic [31:0] status_word;
  logic rd_setup;
  logic wr_ctrl;

  // Switch pattern to mode; any other pattern is refused as invalid
  function automatic rsadc_pkg::rsadc_mode_t decode_mode(input logic [4:0] s);
    rsadc_pkg::rsadc_mode_t m;
    m = rsadc_pkg::MODE_INVALID;
    if (s == rsadc_pkg::SW_RS422) begin
      m = rsadc_pkg::MODE_RS422;
    end else if (s == rsadc_pkg::SW_RS485_4W) begin
      m = rsadc_pkg::MODE_RS485_4W;
    end else if (s == rsadc_pkg::SW_RS485_2W) begin
      m = rsadc_pkg::MODE_RS485_2W;
    end
    return m;
  endfunction

  // Mapped register offsets
  function automatic logic addr_hit(input logic [rsadc_pkg::ADDR_W-1:0] a);
    return (a == rsadc_pkg::CTRL_OFS) || (a == rsadc_pkg::STATUS_OFS) ||
           (a == rsadc_pkg::HOLD_OFS);
  endfunction

  // Driver enable is active low: off unless the direction is send
  function automatic logic driver_off(input rsadc_pkg::rsadc_dir_t d);
    return d != rsadc_pkg::DIR_SEND;
  endfunction

  // One step of the hold-off counter, never below zero
  function automatic logic [rsadc_pkg::HOLD_W-1:0] count_down(
    input logic [rsadc_pkg::HOLD_W-1:0] c
  );
    return (c == rsadc_pkg::HOLD_ZERO) ? rsadc_pkg::HOLD_ZERO : c - rsadc_pkg::HOLD_ONE;
  endfunction

  // Read mux; unmapped addresses read zero
  function automatic logic [31:0] read_word(
    input logic [rsadc_pkg::ADDR_W-1:0] a,
    input logic ok,
    input logic [rsadc_pkg::CTRL_W-1:0] ctrl,
    input logic [31:0] status,
    input logic [rsadc_pkg::HOLD_W-1:0] cnt
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    if (ok && (a == rsadc_pkg::CTRL_OFS)) begin
      w = {25'h0000000, ctrl};
    end else if (ok && (a == rsadc_pkg::STATUS_OFS)) begin
      w = status;
    end else if (ok && (a == rsadc_pkg::HOLD_OFS)) begin
      w = {22'h000000, cnt};
    end
    return w;
  endfunction

  assign raw_in = {holdoff_delay_select, mode_select_bit_e, mode_select_bit_d,
                   mode_select_bit_c, mode_select_bit_b, mode_select_bit_a,
                   line_hs_i, line_data_i, hs_in, tx_data_in};

  // Every pin input passes the three-flop filter
  rsadc_sync #(
    .W(rsadc_pkg::SYNC_W),
    .RESET_VAL(rsadc_pkg::SYNC_RESET)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(raw_in),
    .sync_out(syn)
  );

  assign tx_s = syn[0];
  assign hs_s = syn[1];
  assign line_rx_s = syn[2];
  assign line_hs_s = syn[3];
  assign pin_sw = syn[8:4];
  assign pin_delay = syn[9];

  // Switch source: pins, or the control register when software overrides
  assign sw = q.ctrl[rsadc_pkg::CTRL_USE_REG] ?
              q.ctrl[rsadc_pkg::CTRL_SW_MSB:rsadc_pkg::CTRL_SW_LSB] : pin_sw;
  assign delay_sel = q.ctrl[rsadc_pkg::CTRL_USE_REG] ?
                     q.ctrl[rsadc_pkg::CTRL_DELAY] : pin_delay;
  assign mode = decode_mode(sw);
  assign rs485 = (mode == rsadc_pkg::MODE_RS485_4W) || (mode == rsadc_pkg::MODE_RS485_2W);
  assign activity = (tx_s != rsadc_pkg::LINE_IDLE) || (tx_s != q.tx_prev);
  assign hold_len = delay_sel ? SHORT_LEN : LONG_LEN;

  assign addr = paddr[rsadc_pkg::ADDR_W-1:0];
  assign hit = addr_hit(addr) && (paddr[31:rsadc_pkg::ADDR_W] == '0);
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_ctrl = psel && penable && pwrite && hit && (addr == rsadc_pkg::CTRL_OFS);

  // Status bits read back over the bus
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[rsadc_pkg::STAT_MODE_MSB:rsadc_pkg::STAT_MODE_LSB] = mode;
    status_word[rsadc_pkg::STAT_DELAY] = delay_sel;
    status_word[rsadc_pkg::STAT_DRV] = ~q.data_oe_n;
    status_word[rsadc_pkg::STAT_RX_EN] = q.rx_en;
    status_word[rsadc_pkg::STAT_HS_DRV] = ~q.hs_oe_n;
  end

  always_comb begin
    next_q = q;
    next_q.tx_prev = tx_s;
    next_q.line_tx = tx_s;
    next_q.hs_tx = hs_s;

    // Direction state machine
    case (q.dir)
      rsadc_pkg::DIR_RECEIVE: begin
        if (rs485 && activity) begin
          next_q.dir = rsadc_pkg::DIR_SEND;
          next_q.hold_cnt = hold_len;
        end
      end
      rsadc_pkg::DIR_SEND: begin
        if (!rs485) begin
          next_q.dir = rsadc_pkg::DIR_RECEIVE;
          next_q.hold_cnt = rsadc_pkg::HOLD_ZERO;
        end else if (activity) begin
          next_q.hold_cnt = hold_len;
        end else if (q.hold_cnt <= rsadc_pkg::HOLD_ONE) begin
          next_q.dir = rsadc_pkg::DIR_RECEIVE;
          next_q.hold_cnt = rsadc_pkg::HOLD_ZERO;
        end else begin
          next_q.hold_cnt = count_down(q.hold_cnt);
        end
      end
      default: begin
        next_q.dir = rsadc_pkg::DIR_RECEIVE;
        next_q.hold_cnt = rsadc_pkg::HOLD_ZERO;
      end
    endcase

    // Driver and receiver enables per mode
    case (mode)
      rsadc_pkg::MODE_RS422: begin
        next_q.data_oe_n = 1'b0;
        next_q.hs_oe_n = 1'b0;
        next_q.rx_en = 1'b1;
      end
      rsadc_pkg::MODE_RS485_4W: begin
        next_q.data_oe_n = driver_off(next_q.dir);
        next_q.hs_oe_n = 1'b1;
        next_q.rx_en = 1'b1;
      end
      rsadc_pkg::MODE_RS485_2W: begin
        next_q.data_oe_n = driver_off(next_q.dir);
        next_q.hs_oe_n = 1'b1;
        next_q.rx_en = (next_q.dir == rsadc_pkg::DIR_RECEIVE);
      end
      default: begin
        next_q.data_oe_n = 1'b1;
        next_q.hs_oe_n = 1'b1;
        next_q.rx_en = 1'b0;
      end
    endcase

    // Data toward the local side; idle level when the channel is off
    next_q.rx_data = next_q.rx_en ? line_rx_s : rsadc_pkg::LINE_IDLE;
    next_q.hs_data = (mode == rsadc_pkg::MODE_RS422) ? line_hs_s : rsadc_pkg::LINE_IDLE;

    // APB read data captured in the setup cycle
    if (rd_setup) begin
      next_q.prdata = read_word(addr, hit, q.ctrl, status_word, q.hold_cnt);
    end

    // APB write in the access cycle
    if (wr_ctrl) begin
      next_q.ctrl = pwdata[rsadc_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.prdata <= 32'h0000_0000;
      q.ctrl <= rsadc_pkg::CTRL_RESET;
      q.dir <= rsadc_pkg::DIR_RECEIVE;
      q.hold_cnt <= rsadc_pkg::HOLD_ZERO;
      q.tx_prev <= rsadc_pkg::LINE_IDLE;
      q.line_tx <= rsadc_pkg::LINE_IDLE;
      q.data_oe_n <= 1'b1;
      q.rx_en <= 1'b0;
      q.hs_tx <= rsadc_pkg::LINE_IDLE;
      q.hs_oe_n <= 1'b1;
      q.rx_data <= rsadc_pkg::LINE_IDLE;
      q.hs_data <= rsadc_pkg::LINE_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign rx_data_out = q.rx_data;
  assign hs_out = q.hs_data;
  assign line_data_o = q.line_tx;
  assign line_data_oe_n = q.data_oe_n;
  assign line_hs_o = q.hs_tx;
  assign line_hs_oe_n = q.hs_oe_n;
  assign line_rx_en = q.rx_en;

endmodule
`default_nettype wire

// ===== verification/rsadc_checker.sv
// Port-level assertions for the RS485 direction control block
`timescale 1ns/1ns
`default_nettype none
module rsadc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mode_select_bit_a,
  input wire logic mode_select_bit_b,
  input wire logic mode_select_bit_c,
  input wire logic mode_select_bit_d,
  input wire logic mode_select_bit_e,
  input wire logic holdoff_delay_select,
  input wire logic line_data_o,
  input wire logic line_data_oe_n,
  input wire logic line_hs_oe_n,
  input wire logic line_rx_en
);
  logic [5:0] sw;
  logic [5:0] sw_q;
  logic [3:0] st;
  logic [9:0] idle;
  logic [9:0] hb;
  logic ld_q;
  logic m422;
  logic m4w;
  logic m2w;
  logic map;
  assign sw = {holdoff_delay_select, mode_select_bit_e, mode_select_bit_d,
    mode_select_bit_c, mode_select_bit_b, mode_select_bit_a};
  assign m422 = st == 4'h8 && sw == sw_q && sw[4:0] == rsadc_pkg::SW_RS422;
  assign m4w = st == 4'h8 && sw == sw_q && sw[4:0] == rsadc_pkg::SW_RS485_4W;
  assign m2w = st == 4'h8 && sw == sw_q && sw[4:0] == rsadc_pkg::SW_RS485_2W;
  assign map = paddr == 32'h0 || paddr == 32'h4 || paddr == 32'h8;
  assign hb = holdoff_delay_select ? rsadc_pkg::HOLD_SHORT_CYC - 10'h001 :
    rsadc_pkg::HOLD_LONG_CYC - 10'h001;
  // Switch settle count and idle time of the driven data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_q <= 6'h00;
      st <= 4'h0;
      ld_q <= 1'b1;
      idle <= 10'h000;
    end else begin
      sw_q <= sw;
      st <= (sw != sw_q) ? 4'h0 : st + {3'h0, st != 4'h8};
      ld_q <= line_data_o;
      idle <= (!line_data_o || !ld_q) ? 10'h000 : idle + {9'h000, idle != 10'h3ff};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  access_ready_a: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  decode_err_a: assert property (psel && penable |-> pslverr == !map)
    else $error("pslverr wrong for address");
  rs422_on_a: assert property (m422 |-> !line_data_oe_n && !line_hs_oe_n && line_rx_en)
    else $error("RS422 mode disabled a line");
  hs_off_a: assert property (m4w || m2w |-> line_hs_oe_n)
    else $error("handshake driven in RS485 mode");
  rx_4w_a: assert property (m4w |-> line_rx_en)
    else $error("4-wire receive disabled");
  rx_2w_a: assert property (m2w |-> line_rx_en == line_data_oe_n)
    else $error("2-wire receive not opposite driver");
  drive_on_a: assert property ((m4w || m2w) && !line_data_o |-> !line_data_oe_n)
    else $error("driver off while sending");
  hold_on_a: assert property ((m4w || m2w) && !line_data_oe_n && idle < 10'h05a |=>
    !line_data_oe_n) else $error("driver released too early");
  release_time_a: assert property ($rose(line_data_oe_n) && (m4w || m2w) |->
    idle + 10'h006 >= hb && idle <= hb + 10'h006) else $error("hold-off length wrong");
  cover property ($rose(line_data_oe_n));
  cover property ($fell(line_rx_en));
  cover property (psel && penable && pslverr);
endmodule
bind rsadc_top rsadc_checker rsadc_checker_inst (.*);
`default_nettype wire

// ===== verification/rsadc_line_node.sv
// Far-side bus node feeding the receive pair and handshake line
`timescale 1ns/1ns
`default_nettype none
module rsadc_line_node (
  input wire logic two_wire,
  input wire logic node_en,
  input wire logic node_tx,
  input wire logic node_hs,
  input wire logic line_data_o,
  input wire logic line_data_oe_n,
  output logic line_data_i,
  output logic line_hs_i
);
  // Shared pair carries our own driver in 2-wire; a released line rests at mark
  assign line_data_i = (two_wire && !line_data_oe_n) ? line_data_o : (node_en ? node_tx : 1'b1);
  assign line_hs_i = node_hs;
endmodule
`default_nettype wire

// ===== verification/test_rsadc_top.sv
// Testbench for the RS485 direction control block
`timescale 1ns/1ns
`default_nettype none
module test_rsadc_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic tx_data_in, hs_in, rx_data_out, hs_out, line_data_i, line_data_o, line_data_oe_n;
  logic line_hs_i, line_hs_o, line_hs_oe_n, line_rx_en, holdoff_delay_select;
  logic mode_select_bit_a, mode_select_bit_b, mode_select_bit_c, mode_select_bit_d;
  logic mode_select_bit_e, two_wire, node_en, node_tx, node_hs;
  logic [4:0] msw [3];
  int hold [3];
  int bad_count, num_checks;
  rsadc_top rsadc_top_inst (.*);
  rsadc_line_node rsadc_line_node_inst (.*);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Cut a hung run short
  initial begin
    cyc(20000);
    bad_count++;
    give_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {tx_data_in, hs_in, node_tx, node_hs, holdoff_delay_select} = 5'h1f;
    {mode_select_bit_e, mode_select_bit_d, mode_select_bit_c, mode_select_bit_b,
      mode_select_bit_a, two_wire, node_en} = 7'h00;
    msw = '{rsadc_pkg::SW_RS422, rsadc_pkg::SW_RS485_4W, rsadc_pkg::SW_RS485_2W};
    hold = '{100, 100, 500};
    bad_count = 0;
    num_checks = 0;
    cyc(8);
    presetn <= 1'b1;
    apb(1'b1, 32'h0, 32'h7e);
    apb(1'b0, 32'h0, 32'h0);
    chk("ctrl", rd, 32'h7e);
    apb(1'b1, 32'h8, 32'h3ff);
    apb(1'b0, 32'h8, 32'h0);
    chk("hold_reg", rd, 32'h0);
    apb(1'b1, 32'hc, 32'h1);
    chk("err_wr", er, 1'b1);
    apb(1'b0, 32'hc, 32'h0);
    chk("err_rd", {rd[30:0], er}, 32'h1);
    // One telegram per mode: drive, gap, hold-off, release
    for (int m = 0; m < 3; m++) begin
      {mode_select_bit_e, mode_select_bit_d, mode_select_bit_c, mode_select_bit_b,
        mode_select_bit_a} <= msw[m];
      holdoff_delay_select <= m < 2;
      two_wire <= m == 2;
      node_en <= 1'b1;
      cyc(10);
      {tx_data_in, node_tx, node_hs, hs_in} <= 4'h0;
      cyc(10);
      chk("drv_on", line_data_oe_n, 1'b0);
      chk("line_o", line_data_o, 1'b0);
      chk("rx_on", line_rx_en, m < 2);
      chk("rx_out", rx_data_out, m == 2);
      chk("hs_oe_n", line_hs_oe_n, m > 0);
      chk("hs_out", hs_out, m > 0);
      if (m == 0) chk("hs_o", line_hs_o, 1'b0);
      if (m == 1) apb(1'b0, 32'h4, 32'h0);
      if (m == 1) chk("status", rd, 32'h1d);
      tx_data_in <= 1'b1;
      cyc(50);
      chk("gap", line_data_oe_n, 1'b0);
      tx_data_in <= 1'b0;
      cyc(10);
      tx_data_in <= 1'b1;
      cyc(hold[m] - 6);
      chk("holdoff", line_data_oe_n, 1'b0);
      cyc(20);
      chk("release", line_data_oe_n, m > 0);
      chk("line_idle", line_data_o, 1'b1);
      chk("rx_back", line_rx_en, 1'b1);
      chk("rx_data", rx_data_out, 1'b0);
      {node_tx, node_hs, hs_in} <= 3'h7;
    end
    {mode_select_bit_b, mode_select_bit_a, mode_select_bit_d} <= 3'h0;
    cyc(10);
    chk("bad_oe", line_data_oe_n, 1'b1);
    chk("bad_rx", line_rx_en, 1'b0);
    // Switches from the control register: 2-wire, long hold-off
    apb(1'b1, 32'h0, 32'h17);
    apb(1'b0, 32'h4, 32'h0);
    chk("sw_status", rd, 32'h12);
    chk("sw_rx", line_rx_en, 1'b1);
    tx_data_in <= 1'b0;
    cyc(10);
    chk("sw_drv", line_data_oe_n, 1'b0);
    chk("sw_rx_off", line_rx_en, 1'b0);
    apb(1'b0, 32'h8, 32'h0);
    chk("hold_run", rd, 32'h1f4);
    give_verdict();
  end
endmodule
`default_nettype wire
